// File: hdl/vciw_top.sv
/*
  VCO indirect register writer: an AXI4-Lite slave holding the indirect
  access register, unpacking it into three VCO registers, and starting
  a frequency update on the final PLL register write.
  Assumes one 10 MHz clock and a well-behaved AXI4-Lite master.
*/
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module vciw_top
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // VCO controls
  output logic [1:0]       main_rf_output_pwr,
  output logic [2:0]       vco_bias,
  output logic [1:0]       div_out_pwr,
  output logic             div_out_en,
  output logic [2:0]       div_ratio,
  output logic [6:0]       div_shift,
  output logic             vco_power_down,
  output logic             tune_voltage_pin_sel,
  output logic [7:0]       subband,
  output logic             lower_core,
  output logic [6:0]       core_subband,
  output logic             freq_update,
  output logic             autocal_armed
);

  // ****************************************
  // Address decode helpers
  // ****************************************
  function automatic logic [7:0] addr_idx(input logic [31:0] a);
    addr_idx = a[9:2];
  endfunction

  function automatic logic known_wr(input logic [7:0] i);
    known_wr = (i == vciw_pkg::REG_IDX_INDIRECT) ||
               (i == vciw_pkg::REG_IDX_PLL_INT) ||
               (i == vciw_pkg::REG_IDX_PLL_FRAC);
  endfunction

  // ****************************************
  // Write channel
  // ****************************************
  logic        aw_held_q;
  logic [31:0] awaddr_q;
  logic        w_held_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic [7:0]  wr_idx;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_go  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = addr_idx(awaddr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
    end
    else if (wr_go)
      aw_held_q <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end
    else if (wr_go)
      w_held_q <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= vciw_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_wr(wr_idx) ? vciw_pkg::RESP_OKAY
                                       : vciw_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ****************************************
  // Indirect access and VCO registers
  // ****************************************
  // Indirect word is 16 bits; only the two low lanes matter
  logic        ind_wr;
  logic [15:0] ind_word;
  logic [2:0]  ind_id;
  logic [3:0]  ind_addr;
  logic [8:0]  ind_data;
  logic [8:0]  vco0_q;
  logic [8:0]  vco1_q;
  logic [8:0]  vco2_q;

  assign ind_wr   = wr_go && (wr_idx == vciw_pkg::REG_IDX_INDIRECT)
                    && (wstrb_q[1:0] == 2'h3);
  assign ind_word = wdata_q[15:0];
  assign ind_id   = ind_word[vciw_pkg::ID_MSB:vciw_pkg::ID_LSB];
  assign ind_addr = ind_word[vciw_pkg::ADDR_MSB:vciw_pkg::ADDR_LSB];
  assign ind_data = ind_word[vciw_pkg::DATA_MSB:vciw_pkg::DATA_LSB];

  // Unknown subsystem ids and addresses are dropped silently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vco0_q <= vciw_pkg::VCO0_RESET;
      vco1_q <= vciw_pkg::VCO1_RESET;
      vco2_q <= vciw_pkg::VCO2_RESET;
    end
    else if (ind_wr && ind_id == vciw_pkg::VCO_SUBSYS_ID)
    begin
      case (ind_addr)
        vciw_pkg::VCO_ADDR_BAND: vco0_q <= ind_data;
        vciw_pkg::VCO_ADDR_PWR:  vco1_q <= ind_data;
        vciw_pkg::VCO_ADDR_DIV:  vco2_q <= ind_data;
        default:                 vco0_q <= vco0_q;
      endcase
    end
  end

  // Field outputs of the VCO registers
  assign main_rf_output_pwr   = vco1_q[1:0];
  assign vco_bias             = vco1_q[4:2];
  assign div_out_pwr          = vco1_q[6:5];
  assign div_out_en           = vco1_q[8];
  assign div_ratio            = vco2_q[2:0];
  // Shift 6 means divide by 64 for ratio one
  assign div_shift            = 7'(3'h7 - div_ratio);
  assign vco_power_down       = vco2_q[3];
  assign tune_voltage_pin_sel = vco0_q[0];
  assign subband              = vco0_q[8:1];
  assign lower_core           = subband >= vciw_pkg::LOWER_CORE_BASE;
  assign core_subband         = subband[6:0];

  // ****************************************
  // Frequency update sequencing
  // ****************************************
  // Armed by a zero write to the indirect register; fires on PLL 3 or 4
  logic pll_final_wr;
  assign pll_final_wr = wr_go && ((wr_idx == vciw_pkg::REG_IDX_PLL_INT) ||
                                  (wr_idx == vciw_pkg::REG_IDX_PLL_FRAC));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      autocal_armed <= 1'b0;
    else if (ind_wr && ind_word == 16'h0000)
      autocal_armed <= 1'b1;
    else if (pll_final_wr)
      autocal_armed <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      freq_update <= 1'b0;
    else
      freq_update <= pll_final_wr;
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= vciw_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= vciw_pkg::RESP_OKAY;
      case (addr_idx(s_axi_araddr))
        vciw_pkg::REG_IDX_STATUS: s_axi_rdata <= {31'h0000_0000,
                                                  autocal_armed};
        vciw_pkg::REG_IDX_VCO0:   s_axi_rdata <= {23'h00_0000, vco0_q};
        vciw_pkg::REG_IDX_VCO1:   s_axi_rdata <= {23'h00_0000, vco1_q};
        vciw_pkg::REG_IDX_VCO2:   s_axi_rdata <= {23'h00_0000, vco2_q};
        default:
        begin
          // Indirect register is write only
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= vciw_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_id_gates_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id != vciw_pkg::VCO_SUBSYS_ID |=> $stable(vco1_q))
    else $error("foreign subsystem id changed VCO register");
  a_addr_loads_pwr: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id == 3'h0 && ind_addr == 4'h1
    |=> vco1_q == $past(ind_data))
    else $error("power register not loaded");
  a_pwr_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id == 3'h0 && ind_addr == 4'h1 |=>
    main_rf_output_pwr == $past(ind_word[8:7]) &&
    vco_bias == $past(ind_word[11:9]))
    else $error("power and bias fields wrong");
  a_bias_mode: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id == 3'h0 && ind_addr == 4'h1 &&
    ind_word[11:9] == 3'h7 |=> vco_bias == 3'h7)
    else $error("high performance bias not set");
  a_div_pwr_field: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id == 3'h0 && ind_addr == 4'h1 |=>
    div_out_pwr == $past(ind_word[13:12]))
    else $error("divider power field wrong");
  a_div_enable: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id == 3'h0 && ind_addr == 4'h1 |=>
    div_out_en == $past(ind_word[15]))
    else $error("divider enable wrong");
  a_div_by_64: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_word == 16'h0090 |=> div_shift == 7'h06)
    else $error("divide by 64 not selected");
  a_update_pulse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pll_final_wr |=> freq_update ##1 (!freq_update || $past(pll_final_wr)))
    else $error("frequency update not pulsed");
  a_update_only_final: assert property (
    @(posedge aclk) disable iff (!aresetn)
    freq_update |-> $past(pll_final_wr))
    else $error("frequency update without final write");
  a_armed_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_word == 16'h0000 |=> autocal_armed)
    else $error("clearing write did not arm calibration");
  a_armed_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pll_final_wr |=> !autocal_armed)
    else $error("final write left calibration armed");
  a_band_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id == 3'h0 && ind_addr == 4'h0 |=>
    tune_voltage_pin_sel == $past(ind_word[7]) &&
    lower_core == $past(ind_word[15]))
    else $error("band fields wrong");
  a_lower_core: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_id == 3'h0 && ind_addr == 4'h0 && ind_word[15] |=>
    lower_core && core_subband == $past(ind_word[14:8]))
    else $error("lower core subband not selected");
  a_core_subband: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lower_core |-> core_subband == 7'(subband - 8'h80))
    else $error("lower core subband wrong");
  a_wr_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");
  a_bad_addr_err: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go && !known_wr(wr_idx) |=> s_axi_bresp == vciw_pkg::RESP_SLVERR)
    else $error("unknown write address not refused");
  a_rd_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");

  c_band_write: cover property (@(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_word == 16'hCD00);
  c_pwr_write: cover property (@(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_word == 16'hBF88);
  c_div_write: cover property (@(posedge aclk) disable iff (!aresetn)
    ind_wr && ind_word == 16'h0090);
  c_refused_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !known_wr(wr_idx));
  c_armed_update: cover property (@(posedge aclk) disable iff (!aresetn)
    autocal_armed && pll_final_wr);

endmodule

`default_nettype wire

// File: include/vciw_pkg.sv
/*
  Constants for the VCO indirect register writer: register offsets,
  indirect word field layout, VCO register addresses and reset values.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
`default_nettype none

package vciw_pkg;

  // ****************************************
  // Register indices (word offsets, byte address bits 9:2)
  // ****************************************
  localparam logic [7:0] REG_IDX_INDIRECT = 8'h05;
  localparam logic [7:0] REG_IDX_PLL_INT  = 8'h03;
  localparam logic [7:0] REG_IDX_PLL_FRAC = 8'h04;
  localparam logic [7:0] REG_IDX_STATUS   = 8'h20;
  localparam logic [7:0] REG_IDX_VCO0     = 8'h21;
  localparam logic [7:0] REG_IDX_VCO1     = 8'h22;
  localparam logic [7:0] REG_IDX_VCO2     = 8'h23;

  // ****************************************
  // Indirect word field layout
  // ****************************************
  localparam int ID_LSB   = 0;
  localparam int ID_MSB   = 2;
  localparam int ADDR_LSB = 3;
  localparam int ADDR_MSB = 6;
  localparam int DATA_LSB = 7;
  localparam int DATA_MSB = 15;
  localparam logic [2:0] VCO_SUBSYS_ID = 3'h0;

  // ****************************************
  // VCO register addresses and resets
  // ****************************************
  localparam logic [3:0] VCO_ADDR_BAND = 4'h0;
  localparam logic [3:0] VCO_ADDR_PWR  = 4'h1;
  localparam logic [3:0] VCO_ADDR_DIV  = 4'h2;
  localparam logic [8:0] VCO0_RESET    = 9'h020;
  localparam logic [8:0] VCO1_RESET    = 9'h000;
  localparam logic [8:0] VCO2_RESET    = 9'h000;
  localparam logic [7:0] LOWER_CORE_BASE = 8'h80;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// File: verification/vciw_host.sv
/*
  Host controller model: AXI4-Lite master tasks for register access.
  Assumes one clock and a slave that keeps the AXI4-Lite handshakes.
*/
`timescale 1ns/1ps
`default_nettype none

module vciw_host
(
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [31:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [31:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  // Update strobe seen with the response
  input  wire logic        freq_update
);
  // Cycles before bready or rready rise, to stall the slave
  int stall = 0;

  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
     s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] rsp,
                    output logic fu);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (stall == 0);
    forever
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      // Strobe lasts one cycle, so take it when bvalid first shows
      if (s_axi_bvalid && !seen)
      begin
        fu = freq_update;
        seen = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      else if (n >= stall) s_axi_bready <= 1'b1;
    end
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= (stall == 0);
    forever
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      else if (n >= stall) s_axi_rready <= 1'b1;
    end
  endtask
endmodule

`default_nettype wire

// File: verification/vco_indirect_register_writer_tb.sv
/*
  Self-checking bench: host model drives the register bus, a local
  model predicts VCO fields, status and responses.
  Assumes the package constants and the one-clock register slave.
*/
`timescale 1ns/1ps
`default_nettype none

module vco_indirect_register_writer_tb;
  localparam logic [31:0] IND = 32'(vciw_pkg::REG_IDX_INDIRECT) << 2;
  localparam logic [31:0] P3  = 32'(vciw_pkg::REG_IDX_PLL_INT) << 2;
  localparam logic [31:0] P4  = 32'(vciw_pkg::REG_IDX_PLL_FRAC) << 2;
  localparam logic [31:0] ST  = 32'(vciw_pkg::REG_IDX_STATUS) << 2;
  localparam logic [31:0] V0  = 32'(vciw_pkg::REG_IDX_VCO0) << 2;
  localparam logic [31:0] OK  = 32'(vciw_pkg::RESP_OKAY);
  localparam logic [31:0] ERR = 32'(vciw_pkg::RESP_SLVERR);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, main_rf_output_pwr, div_out_pwr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, div_out_en, vco_power_down;
  logic tune_voltage_pin_sel, lower_core, freq_update, autocal_armed;
  logic [2:0] vco_bias, div_ratio;
  logic [6:0] div_shift, core_subband;
  logic [7:0] subband;
  logic [8:0] vco [3];
  logic armed;
  logic [31:0] seed = 32'h319C711B;
  logic [15:0] w;
  int bad_count = 0;
  int comparisons = 0;

  vciw_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .main_rf_output_pwr, .vco_bias, .div_out_pwr, .div_out_en, .div_ratio,
    .div_shift, .vco_power_down, .tune_voltage_pin_sel, .subband, .lower_core,
    .core_subband, .freq_update, .autocal_armed);
  vciw_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .freq_update);

  // ****************************************
  // Checking tasks
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_out();
    chk("rf_pwr", 32'(vco[1][1:0]), 32'(main_rf_output_pwr));
    chk("bias", 32'(vco[1][4:2]), 32'(vco_bias));
    chk("div_pwr", 32'(vco[1][6:5]), 32'(div_out_pwr));
    chk("div_en", 32'(vco[1][8]), 32'(div_out_en));
    chk("ratio", 32'(vco[2][2:0]), 32'(div_ratio));
    chk("shift", 7 - 32'(vco[2][2:0]), 32'(div_shift));
    chk("pd", 32'(vco[2][3]), 32'(vco_power_down));
    chk("vt_sel", 32'(vco[0][0]), 32'(tune_voltage_pin_sel));
    chk("subband", 32'(vco[0][8:1]), 32'(subband));
    chk("lower", 32'(vco[0][8]), 32'(lower_core));
    chk("core", vco[0][8] ? 32'(vco[0][8:1]) - 128 : 32'(vco[0][8:1]),
        32'(core_subband));
    chk("armed", 32'(armed), 32'(autocal_armed));
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [1:0] rsp;
    logic fu;
    logic go;
    host.wr(a, d, s, rsp, fu);
    go = (a == IND) && (s[1:0] == 2'h3);
    // Id must match and address must exist
    if (go && d[2:0] == 3'h0 && d[6:3] < 4'h3) vco[d[6:3]] = d[15:7];
    if (go && d[15:0] == 16'h0) armed = 1'b1;
    if (a == P3 || a == P4) armed = 1'b0;
    chk("bresp", (go || a == IND || a == P3 || a == P4) ? OK : ERR,
        32'(rsp));
    chk("freq_update", 32'(a == P3 || a == P4), 32'(fu));
    chk_out();
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] r);
    logic [31:0] d;
    logic [1:0] rsp;
    host.rd(a, d, rsp);
    chk("rdata", e, d);
    chk("rresp", r, 32'(rsp));
  endtask

  task automatic finish_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial
  begin
    forever #50 aclk = ~aclk;
  end

  initial
  begin
    repeat (8000) @(posedge aclk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    vco = '{vciw_pkg::VCO0_RESET, vciw_pkg::VCO1_RESET, vciw_pkg::VCO2_RESET};
    armed = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) rdc(V0 + 4 * i, 32'(vco[i]), OK);
    rdc(ST, 32'h0, OK);
    rdc(IND, 32'h0, ERR);
    wr(IND, 32'h0, 4'hF);
    rdc(ST, 32'h1, OK);
    wr(IND, 32'h0090, 4'hF);
    wr(IND, 32'hBF88, 4'hF);
    wr(IND, 32'hCD00, 4'hF);
    wr(P3, 32'h0, 4'hF);
    rdc(ST, 32'h0, OK);
    wr(IND, 32'h0091, 4'hF);
    wr(IND, 32'h0098, 4'hF);
    wr(IND, 32'h3F88, 4'h1);
    wr(32'h18, 32'hFFFF, 4'hF);
    host.stall = 3;
    wr(IND, 32'h3F88, 4'hF);
    wr(P4, 32'h0, 4'hF);
    rdc(V0 + 4, 32'(vco[1]), OK);
    host.stall = 0;
    for (int k = 0; k < 30; k++)
    begin
      seed = lfsr_next(seed);
      w = seed[15:0];
      if (seed[16]) w[2:0] = 3'h0;
      if (w[6:3] == 4'h1) w[14] = 1'b0;
      wr(IND, 32'(w), 4'hF);
      rdc(V0 + 4 * (k % 3), 32'(vco[k % 3]), OK);
    end
    // Mid-run reset must bring every register back to its reset value
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    vco = '{vciw_pkg::VCO0_RESET, vciw_pkg::VCO1_RESET, vciw_pkg::VCO2_RESET};
    armed = 1'b0;
    @(posedge aclk);
    chk_out();
    rdc(V0, 32'(vco[0]), OK);
    finish_test();
  end
endmodule

`default_nettype wire
